//--- src/brake_seq_pkg.sv
`default_nettype none
package brake_seq_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_NS         = 1_000_000;
  // Cycles in one millisecond, rounded up
  localparam int unsigned MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Field widths
  localparam int unsigned DUR_W = 16;
  localparam int unsigned SPD_W = 16;

  // Reset values
  localparam logic [SPD_W-1:0] RST_SETPOINT = 16'h0000;
  localparam logic [DUR_W-1:0] RST_COUNT    = 16'h0000;

  typedef enum logic [2:0] {
    ST_OFF       = 3'b000,
    ST_RUN_DLY   = 3'b001,
    ST_ON        = 3'b010,
    ST_STOP_RAMP = 3'b011,
    ST_STOP_DLY  = 3'b100,
    ST_AUTO      = 3'b101
  } seq_state_t;

  // Configuration from the drive's parameter store
  typedef struct packed {
    logic [DUR_W-1:0] run_delay_ms;
    logic [DUR_W-1:0] stop_delay_ms;
    logic [DUR_W-1:0] idle_ms;
    logic [SPD_W-1:0] speed_thresh;
    logic             auto_brake_on;
    logic             torque_mode;
  } seq_cfg_t;

  // Status reported to the drive
  typedef struct packed {
    logic drive_enabled;
    logic stage_on;
    logic brake_released;
    logic hold_position;
    logic auto_braked;
    logic run_delay_busy;
  } seq_status_t;

  localparam seq_status_t RST_STATUS = '{default: 1'b0};

endpackage : brake_seq_pkg
`default_nettype wire

//--- src/ms_tick_gen.sv
`default_nettype none
module ms_tick_gen #(
  parameter int unsigned MS_CYCLES = brake_seq_pkg::MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int unsigned CW = $clog2(MS_CYCLES);

  if (MS_CYCLES < 2) begin : g_chk
    $error("ms_tick_gen: MS_CYCLES must be at least 2");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;
  logic          tick_q;

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + CW'(1);
    if (cnt_q == CW'(MS_CYCLES - 1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : ms_tick_gen
`default_nettype wire

//--- src/ms_timer.sv
`default_nettype none
module ms_timer #(
  parameter int unsigned DUR_W = brake_seq_pkg::DUR_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [DUR_W-1:0] dur,
  input  wire logic             tick,
  output logic                  done
);

  if (DUR_W < 2) begin : g_chk
    $error("ms_timer: DUR_W must be at least 2");
  end

  logic [DUR_W-1:0] cnt_q;
  logic [DUR_W-1:0] cnt_d;
  logic             run_q;
  logic             run_d;
  logic             exp_q;
  logic             exp_d;

  // The tick after the count reaches zero ends it, so the delay is never short
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = exp_q;
    if (load) begin
      cnt_d = dur;
      run_d = 1'b1;
      exp_d = 1'b0;
    end else if (run_q && tick) begin
      if (cnt_q != '0) begin
        cnt_d = cnt_q - DUR_W'(1);
      end else begin
        exp_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= brake_seq_pkg::RST_COUNT;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign done = run_q && exp_q && !load;

endmodule : ms_timer
`default_nettype wire

//--- src/holding_brake_sequencer.sv
// Operation
// - One output drives brake, released on enable
// - Run and stop delays are configurable
// - Speed setpoint held zero during run delay
// - Setpoints and starts ignored during run delay
// - Torque mode bypasses both delays
// - Disable: zero speed, brake at standstill, delay
// - Hold position in stop delay, then disable
// - Idle timeout engages brake, stage off
// - Automatic brake only when switched on
// - Drive still reports enabled under automatic brake
// - New positioning start re-enables stage itself
`default_nettype none
module holding_brake_sequencer #(
  parameter int unsigned MS_CYCLES = brake_seq_pkg::MS_CYCLES,
  parameter int unsigned DUR_W     = brake_seq_pkg::DUR_W,
  parameter int unsigned SPD_W     = brake_seq_pkg::SPD_W
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      enable_req,
  input  wire brake_seq_pkg::seq_cfg_t   cfg,
  input  wire logic signed [SPD_W-1:0]   speed_act,
  input  wire logic signed [SPD_W-1:0]   speed_set_in,
  input  wire logic signed [SPD_W-1:0]   torque_set_in,
  input  wire logic                      pos_start,
  output logic                           brake_release_q,
  output logic signed [SPD_W-1:0]        speed_set_q,
  output logic signed [SPD_W-1:0]        torque_set_q,
  output logic                           pos_start_q,
  output brake_seq_pkg::seq_status_t     status_q,
  output brake_seq_pkg::seq_state_t      state_q
);

  if (SPD_W != brake_seq_pkg::SPD_W || DUR_W != brake_seq_pkg::DUR_W) begin : g_chk
    $error("holding_brake_sequencer: widths must match the configuration record");
  end

  brake_seq_pkg::seq_state_t   state_d;
  brake_seq_pkg::seq_status_t  status_d;
  logic                        brake_release_d;
  logic signed [SPD_W-1:0]     speed_set_d;
  logic signed [SPD_W-1:0]     torque_set_d;
  logic                        pos_start_d;
  logic                        pend_q;
  logic                        pend_d;

  logic                        ms_tick;
  logic                        dly_load;
  logic [DUR_W-1:0]            dly_dur;
  logic                        dly_done;
  logic                        idle_load;
  logic                        idle_done;

  logic [SPD_W:0]              speed_abs;
  logic                        at_standstill;
  logic                        moving;
  logic                        idle_armed;

  ms_tick_gen #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (ms_tick)
  );

  // Shared by run delay and stop delay; they never overlap
  ms_timer #(
    .DUR_W (DUR_W)
  ) u_dly (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (dly_load),
    .dur   (dly_dur),
    .tick  (ms_tick),
    .done  (dly_done)
  );

  ms_timer #(
    .DUR_W (DUR_W)
  ) u_idle (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (idle_load),
    .dur   (cfg.idle_ms),
    .tick  (ms_tick),
    .done  (idle_done)
  );

  // Magnitude one bit wider so the most negative speed cannot wrap
  always_comb begin
    speed_abs = speed_act[SPD_W-1] ? ((SPD_W+1)'(0) - {speed_act[SPD_W-1], speed_act})
                                   : {1'b0, speed_act};
    at_standstill = (speed_abs <= {1'b0, cfg.speed_thresh});
    moving        = !at_standstill || pos_start;
  end

  // Idle timer keeps reloading while it may not count or the motor moves
  always_comb begin
    idle_armed = (state_q == brake_seq_pkg::ST_ON) && cfg.auto_brake_on
                 && !cfg.torque_mode;
    idle_load  = !idle_armed || moving;
  end

  // Sequence control
  always_comb begin
    state_d      = state_q;
    pend_d       = pend_q;
    speed_set_d  = brake_seq_pkg::RST_SETPOINT;
    torque_set_d = brake_seq_pkg::RST_SETPOINT;
    pos_start_d  = 1'b0;
    dly_load     = 1'b0;
    dly_dur      = cfg.run_delay_ms;
    case (state_q)
      brake_seq_pkg::ST_OFF: begin
        pend_d = 1'b0;
        if (enable_req) begin
          if (cfg.torque_mode) begin
            state_d = brake_seq_pkg::ST_ON;
          end else begin
            state_d  = brake_seq_pkg::ST_RUN_DLY;
            dly_load = 1'b1;
            dly_dur  = cfg.run_delay_ms;
          end
        end
      end
      brake_seq_pkg::ST_RUN_DLY: begin
        // Setpoint stays zero; incoming starts are dropped
        speed_set_d = brake_seq_pkg::RST_SETPOINT;
        if (!enable_req) begin
          pend_d  = 1'b0;
          state_d = brake_seq_pkg::ST_STOP_RAMP;
        end else if (dly_done) begin
          state_d     = brake_seq_pkg::ST_ON;
          pos_start_d = pend_q;
          pend_d      = 1'b0;
        end
      end
      brake_seq_pkg::ST_ON: begin
        if (cfg.torque_mode) begin
          torque_set_d = torque_set_in;
        end else begin
          speed_set_d = speed_set_in;
          pos_start_d = pos_start;
        end
        if (!enable_req) begin
          if (cfg.torque_mode) begin
            state_d = brake_seq_pkg::ST_OFF;
          end else begin
            speed_set_d = brake_seq_pkg::RST_SETPOINT;
            pos_start_d = 1'b0;
            state_d     = brake_seq_pkg::ST_STOP_RAMP;
          end
        end else if (idle_armed && idle_done) begin
          speed_set_d = brake_seq_pkg::RST_SETPOINT;
          pos_start_d = 1'b0;
          state_d     = brake_seq_pkg::ST_AUTO;
        end
      end
      brake_seq_pkg::ST_STOP_RAMP: begin
        speed_set_d = brake_seq_pkg::RST_SETPOINT;
        if (cfg.torque_mode) begin
          state_d = brake_seq_pkg::ST_OFF;
        end else if (at_standstill) begin
          state_d  = brake_seq_pkg::ST_STOP_DLY;
          dly_load = 1'b1;
          dly_dur  = cfg.stop_delay_ms;
        end
      end
      brake_seq_pkg::ST_STOP_DLY: begin
        speed_set_d = brake_seq_pkg::RST_SETPOINT;
        if (dly_done) begin
          state_d = brake_seq_pkg::ST_OFF;
        end
      end
      brake_seq_pkg::ST_AUTO: begin
        if (!enable_req) begin
          state_d = brake_seq_pkg::ST_OFF;
        end else if (pos_start) begin
          // Stage back on, start is passed once the brake is open
          state_d  = brake_seq_pkg::ST_RUN_DLY;
          pend_d   = 1'b1;
          dly_load = 1'b1;
          dly_dur  = cfg.run_delay_ms;
        end
      end
      default: begin
        state_d = brake_seq_pkg::ST_OFF;
      end
    endcase
  end

  // Outputs follow the next state so they change with it
  always_comb begin
    status_d        = brake_seq_pkg::RST_STATUS;
    brake_release_d = 1'b0;
    case (state_d)
      brake_seq_pkg::ST_RUN_DLY: begin
        status_d.drive_enabled  = 1'b1;
        status_d.stage_on       = 1'b1;
        status_d.run_delay_busy = 1'b1;
        brake_release_d         = 1'b1;
      end
      brake_seq_pkg::ST_ON: begin
        status_d.drive_enabled = 1'b1;
        status_d.stage_on      = 1'b1;
        brake_release_d        = 1'b1;
      end
      brake_seq_pkg::ST_STOP_RAMP: begin
        status_d.drive_enabled = 1'b1;
        status_d.stage_on      = 1'b1;
        brake_release_d        = 1'b1;
      end
      brake_seq_pkg::ST_STOP_DLY: begin
        status_d.drive_enabled = 1'b1;
        status_d.stage_on      = 1'b1;
        status_d.hold_position = 1'b1;
        brake_release_d        = 1'b0;
      end
      brake_seq_pkg::ST_AUTO: begin
        status_d.drive_enabled = 1'b1;
        status_d.auto_braked   = 1'b1;
        status_d.stage_on      = 1'b0;
        brake_release_d        = 1'b0;
      end
      default: begin
        status_d        = brake_seq_pkg::RST_STATUS;
        brake_release_d = 1'b0;
      end
    endcase
    status_d.brake_released = brake_release_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q         <= brake_seq_pkg::ST_OFF;
      pend_q          <= 1'b0;
      brake_release_q <= 1'b0;
      speed_set_q     <= brake_seq_pkg::RST_SETPOINT;
      torque_set_q    <= brake_seq_pkg::RST_SETPOINT;
      pos_start_q     <= 1'b0;
      status_q        <= brake_seq_pkg::RST_STATUS;
    end else begin
      state_q         <= state_d;
      pend_q          <= pend_d;
      brake_release_q <= brake_release_d;
      speed_set_q     <= speed_set_d;
      torque_set_q    <= torque_set_d;
      pos_start_q     <= pos_start_d;
      status_q        <= status_d;
    end
  end

endmodule : holding_brake_sequencer
`default_nettype wire

//--- tb/brake_seq_asserts.sv
`default_nettype none
module brake_seq_asserts (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         enable_req,
  input wire brake_seq_pkg::seq_cfg_t      cfg,
  input wire logic signed [15:0]           speed_act,
  input wire logic signed [15:0]           torque_set_in,
  input wire logic                         pos_start,
  input wire logic                         brake_release_q,
  input wire logic signed [15:0]           speed_set_q,
  input wire logic signed [15:0]           torque_set_q,
  input wire logic                         pos_start_q,
  input wire brake_seq_pkg::seq_status_t   status_q,
  input wire brake_seq_pkg::seq_state_t    state_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mag;
  assign mag = speed_act[15] ? 16'(-speed_act) : speed_act;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_enable_open: assert property (state_q == brake_seq_pkg::ST_OFF && enable_req
    && !cfg.torque_mode |=> state_q == brake_seq_pkg::ST_RUN_DLY && brake_release_q)
    else $error("enable did not open brake");
  a_run_zero: assert property (state_q == brake_seq_pkg::ST_RUN_DLY |->
    speed_set_q == 16'h0000 && !pos_start_q) else $error("motion during run delay");
  a_torque_direct: assert property (state_q == brake_seq_pkg::ST_OFF && enable_req
    && cfg.torque_mode |=> state_q == brake_seq_pkg::ST_ON) else $error("torque delayed");
  a_torque_pass: assert property (state_q == brake_seq_pkg::ST_ON && cfg.torque_mode
    && enable_req |=> torque_set_q == $past(torque_set_in)) else $error("torque not applied");
  a_ramp_zero: assert property (state_q == brake_seq_pkg::ST_STOP_RAMP |->
    speed_set_q == 16'h0000 && brake_release_q) else $error("stop ramp wrong");
  a_ramp_lock: assert property (state_q == brake_seq_pkg::ST_STOP_RAMP &&
    !cfg.torque_mode && mag <= cfg.speed_thresh |=> state_q == brake_seq_pkg::ST_STOP_DLY
    && !brake_release_q) else $error("brake not locked at standstill");
  a_stop_hold: assert property (state_q == brake_seq_pkg::ST_STOP_DLY |->
    status_q.hold_position && status_q.stage_on && !brake_release_q)
    else $error("position not held");
  a_auto_status: assert property (state_q == brake_seq_pkg::ST_AUTO |->
    status_q.drive_enabled && !status_q.stage_on && !brake_release_q)
    else $error("automatic brake status wrong");
  a_auto_gate: assert property (state_q == brake_seq_pkg::ST_AUTO &&
    $past(state_q) != brake_seq_pkg::ST_AUTO |-> $past(cfg.auto_brake_on))
    else $error("automatic brake while off");
  a_auto_wake: assert property (state_q == brake_seq_pkg::ST_AUTO && pos_start
    && enable_req |=> state_q == brake_seq_pkg::ST_RUN_DLY && status_q.stage_on)
    else $error("start did not wake stage");
  c_stop_dly: cover property (state_q == brake_seq_pkg::ST_STOP_DLY);
  c_auto: cover property (state_q == brake_seq_pkg::ST_AUTO);
  c_torque: cover property (state_q == brake_seq_pkg::ST_ON && cfg.torque_mode);
endmodule : brake_seq_asserts
bind holding_brake_sequencer brake_seq_asserts u_chk (.clk, .rst_n, .enable_req, .cfg,
  .speed_act, .torque_set_in, .pos_start, .brake_release_q, .speed_set_q, .torque_set_q,
  .pos_start_q, .status_q, .state_q);
`default_nettype wire

//--- tb/brake_motor_model.sv
`default_nettype none
module brake_motor_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               brake_release,
  input  wire logic               stage_on,
  input  wire logic signed [15:0] speed_set,
  output logic signed [15:0]      speed_act
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] tgt;
  // Shaft turns only with the stage on and the brake open
  assign tgt = (stage_on && brake_release) ? speed_set : 16'sh0000;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) speed_act <= 16'sh0000;
    else if (speed_act + 16'sh000A <= tgt) speed_act <= speed_act + 16'sh000A;
    else if (speed_act - 16'sh000A >= tgt) speed_act <= speed_act - 16'sh000A;
    else speed_act <= tgt;
  end
endmodule : brake_motor_model
`default_nettype wire

//--- tb/tb_holding_brake_sequencer.sv
`default_nettype none
module tb_holding_brake_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       clk, rst_n, enable_req, pos_start;
  logic                       brake_release_q, pos_start_q;
  brake_seq_pkg::seq_cfg_t    cfg;
  logic signed [15:0]         speed_act, speed_set_in, torque_set_in;
  logic signed [15:0]         speed_set_q, torque_set_q;
  brake_seq_pkg::seq_status_t status_q;
  brake_seq_pkg::seq_state_t  state_q;
  int                         err_count, checks, n;
  holding_brake_sequencer #(.MS_CYCLES(4)) dut (.clk, .rst_n, .enable_req, .cfg, .speed_act,
    .speed_set_in, .torque_set_in, .pos_start, .brake_release_q, .speed_set_q,
    .torque_set_q, .pos_start_q, .status_q, .state_q);
  brake_motor_model motor (.clk, .rst_n, .brake_release(brake_release_q),
    .stage_on(status_q.stage_on), .speed_set(speed_set_q), .speed_act(speed_act));
  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wait_st(input brake_seq_pkg::seq_state_t s, input int lim);
    n = 0;
    while (state_q !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (state_q !== s) begin
      err_count++;
      $display("CHECK FAILED at %0t: state wait timed out", $time);
      conclude();
    end
  endtask : wait_st
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    enable_req = 1'b0;
    pos_start = 1'b0;
    speed_set_in = 16'sh0064;
    torque_set_in = 16'sh0000;
    cfg = '{16'h0002, 16'h0003, 16'h0001, 16'h0005, 1'b0, 1'b0};
    err_count = 0;
    checks = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    enable_req = 1'b1;
    @(negedge clk);
    chk(state_q, brake_seq_pkg::ST_RUN_DLY, "no run delay");
    chk(brake_release_q, 16'h0001, "brake not released");
    chk(status_q.run_delay_busy, 16'h0001, "run delay not flagged");
    pos_start = 1'b1;
    @(negedge clk);
    pos_start = 1'b0;
    chk(speed_set_q, 16'h0000, "setpoint in run delay");
    @(negedge clk);
    chk(pos_start_q, 16'h0000, "start passed in run delay");
    wait_st(brake_seq_pkg::ST_ON, 40);
    chk(n + 2 >= 10 && n + 2 <= 13, 16'h0001, "run delay length");
    @(negedge clk);
    chk(speed_set_q, 16'h0064, "setpoint not applied");
    chk(status_q.brake_released, 16'h0001, "brake status not open");
    repeat (15) @(negedge clk);
    enable_req = 1'b0;
    @(negedge clk);
    chk(speed_set_q, 16'h0000, "no zero speed on disable");
    chk(brake_release_q, 16'h0001, "brake locked while moving");
    wait_st(brake_seq_pkg::ST_STOP_DLY, 40);
    chk(brake_release_q, 16'h0000, "brake open at standstill");
    chk(status_q.hold_position, 16'h0001, "position not held");
    wait_st(brake_seq_pkg::ST_OFF, 40);
    chk(n >= 14 && n <= 17, 16'h0001, "stop delay length");
    chk(status_q, 16'h0000, "status after disable");
    $display("Test enable and disable done");
    cfg.auto_brake_on = 1'b1;
    speed_set_in = 16'sh0000;
    enable_req = 1'b1;
    wait_st(brake_seq_pkg::ST_ON, 40);
    wait_st(brake_seq_pkg::ST_AUTO, 30);
    chk(status_q.drive_enabled, 16'h0001, "enable lost in auto");
    chk(status_q.stage_on, 16'h0000, "stage on in auto");
    chk(status_q.auto_braked, 16'h0001, "auto brake not flagged");
    chk(brake_release_q, 16'h0000, "brake open in auto");
    pos_start = 1'b1;
    @(negedge clk);
    pos_start = 1'b0;
    chk(state_q, brake_seq_pkg::ST_RUN_DLY, "start ignored in auto");
    chk(status_q.stage_on, 16'h0001, "stage not restarted");
    wait_st(brake_seq_pkg::ST_ON, 40);
    chk(pos_start_q, 16'h0001, "start not forwarded");
    enable_req = 1'b0;
    wait_st(brake_seq_pkg::ST_OFF, 60);
    $display("Test automatic brake done");
    cfg.auto_brake_on = 1'b0;
    enable_req = 1'b1;
    wait_st(brake_seq_pkg::ST_ON, 40);
    repeat (40) @(negedge clk);
    chk(state_q, brake_seq_pkg::ST_ON, "auto brake while off");
    enable_req = 1'b0;
    wait_st(brake_seq_pkg::ST_OFF, 60);
    $display("Test automatic brake off done");
    cfg.torque_mode = 1'b1;
    torque_set_in = 16'sh0123;
    enable_req = 1'b1;
    @(negedge clk);
    chk(state_q, brake_seq_pkg::ST_ON, "torque mode delayed");
    @(negedge clk);
    chk(torque_set_q, 16'h0123, "torque not applied");
    enable_req = 1'b0;
    @(negedge clk);
    chk(state_q, brake_seq_pkg::ST_OFF, "torque stop delayed");
    wait_st(brake_seq_pkg::ST_OFF, 2);
    $display("Test torque mode done");
    conclude();
  end
endmodule : tb_holding_brake_sequencer
`default_nettype wire
